// ==== pspdpc_regs.svh ====
// Register offsets, reset values and sizes of the port S pin control block.
`ifndef PSPDPC_REGS_SVH
`define PSPDPC_REGS_SVH

`define PSPDPC_NPINS        6
`define PSPDPC_ADDR_W       8

`define PSPDPC_OFF_DATA     8'h00
`define PSPDPC_OFF_LEVEL    8'h04
`define PSPDPC_OFF_DIR      8'h08
`define PSPDPC_OFF_PULL_EN  8'h0C
`define PSPDPC_OFF_PULL_POL 8'h10
`define PSPDPC_OFF_OD_SEL   8'h14

`define PSPDPC_RST_PINS     6'h00
`define PSPDPC_RST_OE_N     6'h3F
`define PSPDPC_RST_WORD     32'h0000_0000

`endif

// ==== pspdpc_pkg.sv ====
// Types shared by the port S pin control block.
package pspdpc_pkg;

  // Direction requests and output data from the on-chip peripherals sharing the pins.
  typedef struct packed {
    logic       spi_en;
    logic [5:2] spi_oe;
    logic       bus_clock_output_en;
    logic       second_serial_comm_unit_tx_rt_en;
    logic       second_serial_comm_unit_rx_rt_en;
    logic       pwm3_rt_en;
    logic       pwm2_rt_en;
    logic       serial_comm_unit_en;
    logic [1:0] serial_comm_unit_oe;
    logic       lin_direct_drive_bit_rt_en;
    logic [5:0] periph_do;
  } pspdpc_periph_t;

  typedef struct packed {
    logic [5:0]  port_output_data;
    logic [5:0]  direction_select;
    logic [5:0]  pull_enable;
    logic [5:0]  pull_polarity_select;
    logic [5:0]  open_drain_select;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe_n;
    logic [5:0]  pull_up_en;
    logic [5:0]  pull_down_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pspdpc_state_t;

endpackage

// ==== pspdpc_port.sv ====
// Port S pin level view, direction control with peripheral overrides and pull devices.
//
// Summary of operation
// R1: Level view read returns synchronized pin levels on bits 5 to 0.
// R2: Level view shows real pin level even on driven outputs.
// R3: Direction bit 1 makes pin output, 0 input, unless overridden.
// R4: Enabled SPI forces direction of pins 5 to 2 as it requires, pin 3 only while bus clock output is off.
// R5: Overrides never change the stored direction bits.
// R6: Pin 3 forced output by bus clock, routed second serial tx or PWM.
// R7: Routed external trigger leaves direction of pins 3 and 2 alone.
// R8: Pin 2 forced input by routed serial rx, output by routed PWM.
// R9: Enabled serial unit forces direction of pins 1 and 0.
// R10: Routed LIN direct drive bit forces pin 1 to output.
// R11: Pull enable bit 1 turns pull device on for input pins.
// R12: On outputs the pull enable acts only in open-drain mode.
// R13: Enabled pull device direction follows the polarity select bit.
// R14: Polarity 1 selects pulldown, 0 selects pullup.
// R15: Open-drain drives only low; otherwise push-pull.
// R16: Data read returns stored bit if direction is 1, else pin level.
// R17: Writes to the level view are ignored.
// R18: Pin inputs pass two flip-flops before any read.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "pspdpc_regs.svh"

module pspdpc_port (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire pspdpc_pkg::pspdpc_periph_t periph,
  input  wire logic [5:0]             pin_in,
  output logic      [5:0]             pin_out,
  output logic      [5:0]             pin_oe_n,
  output logic      [5:0]             pull_up_en,
  output logic      [5:0]             pull_down_en
);

  pspdpc_pkg::pspdpc_state_t s_q;
  pspdpc_pkg::pspdpc_state_t s_d;

  logic [5:0] eff_dir;
  logic [5:0] owned;
  logic [5:0] eff_data;
  logic [5:0] drv_oe_n;
  logic [5:0] pu;
  logic [5:0] pd;
  logic       setup;
  logic       wr_en;
  logic       hit;

  // The external trigger input has no direction term here: it only listens.
  always_comb begin
    eff_dir = s_q.direction_select; // R3 R7
    owned   = 6'h00;
    for (int i = 4; i < 6; i++) begin
      if (periph.spi_en) begin
        eff_dir[i] = periph.spi_oe[i]; // R4
        owned[i]   = 1'b1;
      end
    end
    if (periph.bus_clock_output_en) begin
      eff_dir[3] = 1'b1; // R6
      owned[3]   = 1'b1;
    end else if (periph.spi_en) begin
      eff_dir[3] = periph.spi_oe[3]; // R4
      owned[3]   = 1'b1;
    end else if (periph.second_serial_comm_unit_tx_rt_en || periph.pwm3_rt_en) begin
      eff_dir[3] = 1'b1; // R6
      owned[3]   = 1'b1;
    end
    if (periph.spi_en) begin
      eff_dir[2] = periph.spi_oe[2]; // R4
      owned[2]   = 1'b1;
    end else if (periph.second_serial_comm_unit_rx_rt_en) begin
      eff_dir[2] = 1'b0; // R8
      owned[2]   = 1'b1;
    end else if (periph.pwm2_rt_en) begin
      eff_dir[2] = 1'b1; // R8
      owned[2]   = 1'b1;
    end
    if (periph.serial_comm_unit_en) begin
      eff_dir[1:0] = periph.serial_comm_unit_oe; // R9
      owned[1:0]   = 2'h3;
    end else if (periph.lin_direct_drive_bit_rt_en) begin
      eff_dir[1] = 1'b1; // R10
      owned[1]   = 1'b1;
    end
  end

  assign eff_data = (owned & periph.periph_do) | (~owned & s_q.port_output_data);

  generate
    for (genvar g = 0; g < `PSPDPC_NPINS; g++) begin : g_pin
      // Open-drain releases the pin for a high level instead of driving it.
      assign drv_oe_n[g] = ~(eff_dir[g] & (~s_q.open_drain_select[g] | ~eff_data[g])); // R15
      // A pushed-pull output would fight its own pull device, so it stays off.
      assign pu[g] = s_q.pull_enable[g] & (~eff_dir[g] | s_q.open_drain_select[g]) & // R11 R12
                     ~s_q.pull_polarity_select[g]; // R13 R14
      assign pd[g] = s_q.pull_enable[g] & (~eff_dir[g] | s_q.open_drain_select[g]) & // R11 R12
                     s_q.pull_polarity_select[g]; // R13 R14
    end
  endgenerate

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign hit   = (paddr == `PSPDPC_OFF_DATA)     || (paddr == `PSPDPC_OFF_LEVEL) ||
                 (paddr == `PSPDPC_OFF_DIR)      || (paddr == `PSPDPC_OFF_PULL_EN) ||
                 (paddr == `PSPDPC_OFF_PULL_POL) || (paddr == `PSPDPC_OFF_OD_SEL);

  always_comb begin
    s_d              = s_q;
    s_d.sync1        = pin_in; // R18
    s_d.sync2        = s_q.sync1; // R18
    s_d.pin_out      = eff_data;
    s_d.pin_oe_n     = drv_oe_n;
    s_d.pull_up_en   = pu;
    s_d.pull_down_en = pd;
    s_d.pready       = setup;
    s_d.pslverr      = setup & ~hit;
    s_d.prdata       = `PSPDPC_RST_WORD;
    if (setup && !pwrite) begin
      unique case (paddr)
        `PSPDPC_OFF_DATA: begin
          s_d.prdata[5:0] = (s_q.direction_select & s_q.port_output_data) |
                            (~s_q.direction_select & s_q.sync2); // R16
        end
        `PSPDPC_OFF_LEVEL: begin
          s_d.prdata[5:0] = s_q.sync2; // R1 R2
        end
        `PSPDPC_OFF_DIR: begin
          s_d.prdata[5:0] = s_q.direction_select;
        end
        `PSPDPC_OFF_PULL_EN: begin
          s_d.prdata[5:0] = s_q.pull_enable;
        end
        `PSPDPC_OFF_PULL_POL: begin
          s_d.prdata[5:0] = s_q.pull_polarity_select;
        end
        `PSPDPC_OFF_OD_SEL: begin
          s_d.prdata[5:0] = s_q.open_drain_select;
        end
        default: begin
          s_d.prdata = `PSPDPC_RST_WORD;
        end
      endcase
    end
    // Only software writes touch the stored bits; overrides act on eff_dir and eff_data alone.
    if (wr_en) begin
      unique case (paddr)
        `PSPDPC_OFF_DATA: begin
          s_d.port_output_data = pwdata[5:0];
        end
        `PSPDPC_OFF_DIR: begin
          s_d.direction_select = pwdata[5:0]; // R3 R5
        end
        `PSPDPC_OFF_PULL_EN: begin
          s_d.pull_enable = pwdata[5:0]; // R11
        end
        `PSPDPC_OFF_PULL_POL: begin
          s_d.pull_polarity_select = pwdata[5:0]; // R14
        end
        `PSPDPC_OFF_OD_SEL: begin
          s_d.open_drain_select = pwdata[5:0]; // R15
        end
        default: begin
          s_d.direction_select = s_q.direction_select; // R17
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                      <= '0;
      s_q.port_output_data     <= `PSPDPC_RST_PINS;
      s_q.direction_select     <= `PSPDPC_RST_PINS;
      s_q.pull_enable          <= `PSPDPC_RST_PINS;
      s_q.pull_polarity_select <= `PSPDPC_RST_PINS;
      s_q.open_drain_select    <= `PSPDPC_RST_PINS;
      s_q.pin_oe_n             <= `PSPDPC_RST_OE_N;
      s_q.prdata               <= `PSPDPC_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign pin_out      = s_q.pin_out;
  assign pin_oe_n     = s_q.pin_oe_n;
  assign pull_up_en   = s_q.pull_up_en;
  assign pull_down_en = s_q.pull_down_en;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Pin outputs are registered, so most checks look one cycle after their cause.
  // The sync history is only compared once both flops have run two edges out of reset.
  a_level_sync: assert property ($past(presetn, 2) |-> s_q.sync2 == $past(pin_in, 2)) // R18
    else $error("pin level view not two cycles behind pins");

  a_level_read: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_LEVEL |=> // R1
    prdata == {26'h0, $past(s_q.sync2)} && pready)
    else $error("level view read wrong");

  a_driven_level: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_LEVEL && // R2
    !pin_oe_n[0] |=> prdata[0] == $past(s_q.sync2[0]))
    else $error("level view does not show driven pin");

  a_dir_plain: assert property (!periph.spi_en && s_q.direction_select[5] && // R3
    !s_q.open_drain_select[5] |=> !pin_oe_n[5])
    else $error("direction bit did not drive pin 5");

  a_spi_force: assert property (periph.spi_en && !periph.spi_oe[4] |=> // R4
    pin_oe_n[4])
    else $error("spi input request not honoured on pin 4");

  a_dir_kept: assert property (periph.spi_en && !(wr_en && paddr == `PSPDPC_OFF_DIR) |=> // R5
    $stable(s_q.direction_select))
    else $error("override changed stored direction");

  a_clk_out: assert property (periph.bus_clock_output_en && !s_q.open_drain_select[3] |=> // R6
    !pin_oe_n[3])
    else $error("bus clock output did not drive pin 3");

  a_rx_input: assert property (!periph.spi_en && periph.second_serial_comm_unit_rx_rt_en |=> // R8
    pin_oe_n[2])
    else $error("routed serial rx did not make pin 2 input");

  a_sci_force: assert property (periph.serial_comm_unit_en && periph.serial_comm_unit_oe[0] && // R9
    !s_q.open_drain_select[0] |=> !pin_oe_n[0])
    else $error("serial unit output not driven on pin 0");

  a_lin_drive: assert property (!periph.serial_comm_unit_en && periph.lin_direct_drive_bit_rt_en && // R10
    !s_q.open_drain_select[1] |=> !pin_oe_n[1])
    else $error("lin direct drive did not drive pin 1");

  a_pull_pushpull: assert property (eff_dir[5] && !s_q.open_drain_select[5] |=> // R12
    !pull_up_en[5] && !pull_down_en[5])
    else $error("pull device on push-pull output");

  a_pull_polarity: assert property (!eff_dir[4] && s_q.pull_enable[4] && // R13 R14
    s_q.pull_polarity_select[4] |=> pull_down_en[4] && !pull_up_en[4])
    else $error("pulldown not selected");

  a_pull_input: assert property (!eff_dir[4] && s_q.pull_enable[4] && // R11
    !s_q.pull_polarity_select[4] |=> pull_up_en[4] && !pull_down_en[4])
    else $error("pullup not enabled on input");

  a_od_high: assert property (eff_dir[3] && s_q.open_drain_select[3] && eff_data[3] |=> // R15
    pin_oe_n[3])
    else $error("open-drain drove a high level");

  a_data_read: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_DATA && // R16
    s_q.direction_select[0] |=> prdata[0] == $past(s_q.port_output_data[0]))
    else $error("data read ignored stored bit");

  a_ro_write: assert property (wr_en && paddr == `PSPDPC_OFF_LEVEL |=> // R17
    $stable(s_q.direction_select) && $stable(s_q.pull_enable) &&
    $stable(s_q.port_output_data) && $stable(s_q.open_drain_select))
    else $error("write to level view changed state");

  a_spi_out5: assert property (periph.spi_en && periph.spi_oe[5] && !s_q.open_drain_select[5] |=> // R4
    !pin_oe_n[5])
    else $error("spi output request not honoured on pin 5");

  a_spi_in3: assert property (!periph.bus_clock_output_en && periph.spi_en && !periph.spi_oe[3] |=> // R4
    pin_oe_n[3])
    else $error("spi input request not honoured on pin 3");

  a_spi_out2: assert property (periph.spi_en && periph.spi_oe[2] && !s_q.open_drain_select[2] |=> // R4
    !pin_oe_n[2])
    else $error("spi output request not honoured on pin 2");

  a_tx_out3: assert property (!periph.bus_clock_output_en && !periph.spi_en && // R6
    periph.second_serial_comm_unit_tx_rt_en && !s_q.open_drain_select[3] |=> !pin_oe_n[3])
    else $error("routed serial tx did not drive pin 3");

  a_pwm_out3: assert property (!periph.bus_clock_output_en && !periph.spi_en && periph.pwm3_rt_en && // R6
    !s_q.open_drain_select[3] |=> !pin_oe_n[3])
    else $error("routed pwm did not drive pin 3");

  a_pwm_out2: assert property (!periph.spi_en && !periph.second_serial_comm_unit_rx_rt_en && // R8
    periph.pwm2_rt_en && !s_q.open_drain_select[2] |=> !pin_oe_n[2])
    else $error("routed pwm did not drive pin 2");

  a_sci_input: assert property (periph.serial_comm_unit_en && !periph.serial_comm_unit_oe[1] |=> // R9
    pin_oe_n[1])
    else $error("serial unit input not released on pin 1");

  a_dir_input: assert property (!periph.serial_comm_unit_en && !periph.lin_direct_drive_bit_rt_en && // R3
    !s_q.direction_select[1] |=> pin_oe_n[1])
    else $error("cleared direction bit drove pin 1");

  a_data_drive: assert property (!periph.spi_en |=> // R15
    pin_out[5] == $past(s_q.port_output_data[5]))
    else $error("pin 5 does not carry its data bit");

  a_pull_off: assert property (!s_q.pull_enable[2] |=> // R11
    !pull_up_en[2] && !pull_down_en[2])
    else $error("pull device on with pull enable clear");

  a_pull_od: assert property (eff_dir[3] && s_q.open_drain_select[3] && s_q.pull_enable[3] && // R12
    s_q.pull_polarity_select[3] |=> pull_down_en[3] && !pull_up_en[3])
    else $error("pull device off on open-drain output");

  a_od_low: assert property (eff_dir[3] && s_q.open_drain_select[3] && !eff_data[3] |=> // R15
    !pin_oe_n[3])
    else $error("open-drain did not drive a low level");

  a_data_input: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_DATA && // R16
    !s_q.direction_select[1] |=> prdata[1] == $past(s_q.sync2[1]))
    else $error("data read ignored pin level");

  a_dir_read: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_DIR |=> // R3
    prdata == {26'h0, $past(s_q.direction_select)})
    else $error("direction read wrong");

  a_pull_read: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_PULL_EN |=> // R11
    prdata == {26'h0, $past(s_q.pull_enable)})
    else $error("pull enable read wrong");

  a_pol_read: assert property (setup && !pwrite && paddr == `PSPDPC_OFF_PULL_POL |=> // R14
    prdata == {26'h0, $past(s_q.pull_polarity_select)})
    else $error("polarity read wrong");

  a_level_noerr: assert property (setup && paddr == `PSPDPC_OFF_LEVEL |=> // R17
    pready && !pslverr)
    else $error("level view access flagged an error");

  c_spi_on: cover property (periph.spi_en ##1 !periph.spi_en);
  c_od_low: cover property (s_q.open_drain_select[2] && !pin_oe_n[2]);
  c_write_read: cover property (wr_en && paddr == `PSPDPC_OFF_DIR ##2
    setup && paddr == `PSPDPC_OFF_DIR);
  c_lin_drive: cover property (periph.lin_direct_drive_bit_rt_en && !pin_oe_n[1]);
  c_unmapped: cover property (pready && pslverr);

endmodule

// ==== pspdpc_pins_model.sv ====
// Model of the external circuitry seen by the six port S pins.
`timescale 1ns/10ps

module pspdpc_pins_model (
  input  wire logic       pclk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [5:0] pull_up_en,
  input  wire logic [5:0] pull_down_en,
  input  wire logic [5:0] ext_drive,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pin_in
);
  logic [5:0] last = 6'h00;

  // A floating pin flips every cycle, so a stale value can never pass.
  always_ff @(posedge pclk) begin
    last <= pin_in;
  end

  // An outside driver beats the block, which models a shorted output.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (ext_drive[i]) pin_in[i] = ext_val[i];
      else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (pull_down_en[i]) pin_in[i] = 1'b0;
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last[i];
    end
  end
endmodule

// ==== pspdpc_port_test.sv ====
// Register and pin level tests of the port S pin control block.
`timescale 1ns/10ps

module pspdpc_port_test;
  logic                       pclk, presetn, psel, penable, pwrite, e;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, r;
  logic                       pready, pslverr;
  pspdpc_pkg::pspdpc_periph_t periph;
  logic [5:0]                 pin_in, pin_out, pin_oe_n, pu, pd, ext_drive, ext_val;
  int                         n_errors, n_tests, cyc;
  logic [5:0]                 e0 [11] = '{6'h17, 6'h37, 6'h37, 6'h37, 6'h3D, 6'h3B, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h3F};
  logic [5:0]                 e1 [11] = '{6'h14, 6'h00, 6'h00, 6'h00, 6'h04, 6'h00, 6'h02, 6'h00, 6'h38, 6'h34, 6'h03};

  pspdpc_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph(periph), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up_en(pu), .pull_down_en(pd));

  pspdpc_pins_model u_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_up_en(pu), .pull_down_en(pd), .ext_drive(ext_drive), .ext_val(ext_val),
    .pin_in(pin_in));

  always #50 pclk = ~pclk;

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // A hang in the handshake ends the run as a failure.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  function automatic pspdpc_pkg::pspdpc_periph_t mk(input int i);
    pspdpc_pkg::pspdpc_periph_t p;
    p = '0;
    case (i)
      0: p.spi_oe = 4'hA;
      1, 9: p.bus_clock_output_en = 1'b1;
      2: p.second_serial_comm_unit_tx_rt_en = 1'b1;
      3: p.pwm3_rt_en = 1'b1;
      5: p.pwm2_rt_en = 1'b1;
      6: p.serial_comm_unit_oe = 2'h1;
      8: p.spi_oe = 4'h1;
      default: p.lin_direct_drive_bit_rt_en = 1'b1;
    endcase
    p.spi_en = (i == 0 || i == 8 || i == 9);
    p.second_serial_comm_unit_rx_rt_en = (i == 4 || i == 8 || i == 9);
    p.serial_comm_unit_en = (i == 6 || i == 10);
    return p;
  endfunction

  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    periph = '0;
    ext_drive = 6'h00;
    ext_val = 6'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(pin_oe_n), 32'h3F);
    for (int i = 2; i < 6; i++) rd(8'(4 * i), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1);
    $display("test reset done");
    wr(8'h08, 32'h3F);
    wr(8'h00, 32'h2A);
    wt(4);
    chk(32'(pin_oe_n), 32'h00);
    chk(32'(pin_out), 32'h2A);
    rd(8'h04, 32'h2A);
    ext_drive <= 6'h01;
    ext_val <= 6'h01;
    wt(4);
    rd(8'h04, 32'h2B);
    ext_drive <= 6'h00;
    $display("test output done");
    for (int i = 0; i < 11; i++) begin
      periph <= mk(i);
      wr(8'h08, 32'h00);
      wt(2);
      chk(32'(pin_oe_n), 32'(e0[i]));
      wr(8'h08, 32'h3F);
      wt(2);
      chk(32'(pin_oe_n), 32'(e1[i]));
      rd(8'h08, 32'h3F);
    end
    periph.serial_comm_unit_oe <= 2'h3;
    periph.periph_do <= 6'h01;
    wt(2);
    chk(32'(pin_oe_n), 32'h00);
    chk(32'(pin_out), 32'h29);
    rd(8'h04, 32'h29);
    periph <= '0;
    $display("test override done");
    wr(8'h00, 32'h05);
    wr(8'h08, 32'h00);
    wr(8'h0C, 32'h3F);
    wr(8'h10, 32'h0F);
    wt(2);
    chk(32'(pu), 32'h30);
    chk(32'(pd), 32'h0F);
    wr(8'h14, 32'h0F);
    wr(8'h08, 32'h3F);
    wt(2);
    chk(32'(pu), 32'h00);
    chk(32'(pd), 32'h0F);
    chk(32'(pin_oe_n), 32'h05);
    wt(3);
    rd(8'h04, 32'h00);
    rd(8'h00, 32'h05);
    wr(8'h08, 32'h00);
    wt(4);
    rd(8'h00, 32'h30);
    $display("test pull done");
    wr(8'h04, 32'h3F);
    chk(32'(e), 32'h0);
    rd(8'h08, 32'h00);
    rd(8'h00, 32'h30);
    wr(8'h18, 32'h3F);
    chk(32'(e), 32'h1);
    $display("test read only done");
    test_done();
  end
endmodule
